// *** src/nls_host.sv ***
`timescale 1ns/1ps
`include "nls_defines.svh"

// How it works
// - send 7Ah plus block address, read status
// - no lock status read while busy
// - lock pin high 7Ah, low 70h
// - serial read right after power-on
// - wait 10us after power-up before commands
// - hold write-protect low during power-up
// - erase needs setup then confirm command
module nls_host #(
   parameter logic [19:0] BUSY_TIMEOUT_CYC = 20'(`NLS_LBSY_MAX_CYC),
   parameter logic [19:0] LONG_BUSY_CYC = 20'(`NLS_LBSY_MIN_CYC)
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire nls_pkg::nls_req_s req,
   output logic req_ready,
   output logic rsp_valid,
   output nls_pkg::nls_rsp_s rsp,
   input wire logic lock_feature_enable_pin,
   input wire logic rb_n,
   input wire logic [7:0] io_in,
   output nls_pkg::nls_pins_s pins
);

   typedef enum logic [2:0] {
      ST_PWR = 3'h0,
      ST_IDLE = 3'h1,
      ST_WLO = 3'h3,
      ST_WHI = 3'h2,
      ST_BSY = 3'h6,
      ST_RLO = 3'h7,
      ST_RHI = 3'h5,
      ST_DONE = 3'h4
   } nls_state_e;

   nls_state_e state_r;
   nls_pkg::nls_req_s req_r;
   logic lock_mode_r;
   logic [1:0] idx_r;
   logic [8:0] cnt_r;
   logic [19:0] bsy_cnt_r;
   logic timeout_r;
   logic [7:0] data_r;
   logic rb_meta_r;
   logic rb_sync_r;
   logic lock_meta_r;
   logic lock_sync_r;
   logic [7:0] io_meta_r;
   logic [7:0] io_sync_r;
   nls_pkg::nls_cycle_s cyc;

   // one bus cycle of a write sequence, picked by op and position
   function automatic nls_pkg::nls_cycle_s cycle_of(input nls_pkg::nls_op_e op, input logic [1:0] idx,
                                                    input logic [15:0] blk, input logic lock_mode);
      nls_pkg::nls_cycle_s c;
      c = '{cle: 1'b0, ale: 1'b1, last: 1'b0, data: 8'h00};
      case (idx)
         2'h0: begin
            c.cle = 1'b1;
            c.ale = 1'b0;
            if (op == nls_pkg::NLS_OP_ERASE) begin
               c.data = `NLS_CMD_ERASE_SETUP;
            end else if (lock_mode) begin
               c.data = `NLS_CMD_LOCK_STATUS;
            end else begin
               // plain part: no address follows the ordinary status command
               c.data = `NLS_CMD_STATUS;
               c.last = 1'b1;
            end
         end
         2'h1: c.data = blk[7:0];
         2'h2: begin
            c.data = blk[15:8];
            c.last = (op != nls_pkg::NLS_OP_ERASE);
         end
         default: begin
            c.cle = 1'b1;
            c.ale = 1'b0;
            c.data = `NLS_CMD_ERASE_CONFIRM;
            c.last = 1'b1;
         end
      endcase
      return c;
   endfunction : cycle_of

   // two flops on every pin input before any use
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rb_meta_r <= 1'b1;
         rb_sync_r <= 1'b1;
         lock_meta_r <= 1'b0;
         lock_sync_r <= 1'b0;
         io_meta_r <= 8'h00;
         io_sync_r <= 8'h00;
      end else begin
         rb_meta_r <= rb_n;
         rb_sync_r <= rb_meta_r;
         lock_meta_r <= lock_feature_enable_pin;
         lock_sync_r <= lock_meta_r;
         io_meta_r <= io_in;
         io_sync_r <= io_meta_r;
      end
   end

   assign cyc = cycle_of(req_r.op, idx_r, req_r.block, lock_mode_r);

   // requests taken only when idle; queries also wait for ready
   // no query while busy
   assign req_ready = (state_r == ST_IDLE) && (rb_sync_r || req.op != nls_pkg::NLS_OP_PROTECT_QUERY);

   // sequencer and pin drive
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= ST_PWR;
         req_r <= '{op: nls_pkg::NLS_OP_PROTECT_QUERY, block: 16'h0000};
         lock_mode_r <= 1'b0;
         idx_r <= 2'h0;
         cnt_r <= 9'h000;
         pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, output_strobe_n: 1'b1,
                   wp_n: 1'b0, io_oe: 1'b0, io_out: 8'h00};
      end else begin
         case (state_r)
            ST_PWR: begin
               cnt_r <= cnt_r + 9'h001;
               if (cnt_r == 9'(`NLS_PWRUP_CYC - 1)) begin
                  cnt_r <= 9'h000;
                  pins.wp_n <= 1'b1;
                  state_r <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               pins.ce_n <= 1'b1;
               pins.io_oe <= 1'b0;
               if (req_valid && req_ready) begin
                  req_r <= req;
                  lock_mode_r <= lock_sync_r;
                  idx_r <= 2'h0;
                  cnt_r <= 9'h000;
                  pins.ce_n <= 1'b0;
                  state_r <= (req.op == nls_pkg::NLS_OP_SERIAL_READ) ? ST_RLO : ST_WLO;
               end
            end
            ST_WLO: begin
               pins.cle <= cyc.cle;
               pins.ale <= cyc.ale;
               pins.io_out <= cyc.data;
               pins.io_oe <= 1'b1;
               pins.we_n <= 1'b0;
               cnt_r <= cnt_r + 9'h001;
               if (cnt_r == 9'(`NLS_STROBE_CYC - 1)) begin
                  cnt_r <= 9'h000;
                  pins.we_n <= 1'b1;
                  state_r <= ST_WHI;
               end
            end
            ST_WHI: begin
               cnt_r <= cnt_r + 9'h001;
               if (cnt_r == 9'(`NLS_STROBE_CYC - 1)) begin
                  cnt_r <= 9'h000;
                  pins.cle <= 1'b0;
                  pins.ale <= 1'b0;
                  pins.io_oe <= 1'b0;
                  if (!cyc.last) begin
                     idx_r <= idx_r + 2'h1;
                     state_r <= ST_WLO;
                  end else if (req_r.op == nls_pkg::NLS_OP_ERASE) begin
                     state_r <= ST_BSY;
                  end else begin
                     state_r <= ST_RLO;
                  end
               end
            end
            ST_BSY: begin
               if (cnt_r != 9'(`NLS_WB_CYC)) begin
                  cnt_r <= cnt_r + 9'h001;
               end else if (rb_sync_r || timeout_r) begin
                  state_r <= ST_DONE;
               end
            end
            ST_RLO: begin
               // strobe falls with chip select already low
               pins.output_strobe_n <= 1'b0;
               cnt_r <= cnt_r + 9'h001;
               if (cnt_r == 9'(`NLS_STROBE_CYC + 2)) begin
                  cnt_r <= 9'h000;
                  pins.output_strobe_n <= 1'b1;
                  state_r <= ST_RHI;
               end
            end
            ST_RHI: begin
               cnt_r <= cnt_r + 9'h001;
               if (cnt_r == 9'(`NLS_STROBE_CYC - 1)) begin
                  cnt_r <= 9'h000;
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               pins.ce_n <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // busy duration; the line is wired-or so any low device holds us
   // open drain shared line
   always_ff @(posedge ref_clk) begin
      if (rst || state_r != ST_BSY) begin
         bsy_cnt_r <= 20'h00000;
         timeout_r <= 1'b0;
      end else if (cnt_r == 9'(`NLS_WB_CYC) && !rb_sync_r) begin
         bsy_cnt_r <= bsy_cnt_r + 20'h00001;
         timeout_r <= (bsy_cnt_r >= BUSY_TIMEOUT_CYC - 20'h00001);
      end
   end

   // capture late so the synced bus has settled behind the strobe
   // status held live under strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         data_r <= 8'h00;
      end else if (state_r == ST_RLO && cnt_r == 9'(`NLS_STROBE_CYC + 2)) begin
         data_r <= io_sync_r;
      end
   end

   // answer record, one pulse per request
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         rsp_valid <= (state_r == ST_DONE);
         if (state_r == ST_DONE) begin
            rsp.data <= data_r;
            rsp.via_lock_cmd <= lock_mode_r && req_r.op == nls_pkg::NLS_OP_PROTECT_QUERY;
            if (lock_mode_r && req_r.op == nls_pkg::NLS_OP_PROTECT_QUERY) begin
               rsp.unlocked <= data_r[`NLS_LS_UNLOCKED_BIT];
               rsp.locked <= data_r[`NLS_LS_LOCKED_BIT];
               rsp.tight <= data_r[`NLS_LS_TIGHT_BIT];
               rsp.not_protected <= data_r[`NLS_LS_WP_BIT];
            end else begin
               rsp.unlocked <= 1'b0;
               rsp.locked <= 1'b0;
               rsp.tight <= 1'b0;
               rsp.not_protected <= data_r[`NLS_ST_WP_BIT];
            end
            rsp.long_busy <= (req_r.op == nls_pkg::NLS_OP_ERASE) && (bsy_cnt_r >= LONG_BUSY_CYC);
            rsp.timeout <= timeout_r;
         end
      end
   end

endmodule : nls_host

// *** src/nls_defines.svh ***
`ifndef NLS_DEFINES_SVH
`define NLS_DEFINES_SVH

// clock and timing, figures in their own units
`define NLS_CLK_PERIOD_NS 20
`define NLS_STROBE_NS 60
`define NLS_STROBE_CYC ((`NLS_STROBE_NS + `NLS_CLK_PERIOD_NS - 1) / `NLS_CLK_PERIOD_NS)
`define NLS_WB_NS 100
`define NLS_WB_CYC ((`NLS_WB_NS + `NLS_CLK_PERIOD_NS - 1) / `NLS_CLK_PERIOD_NS)
`define NLS_PWRUP_US 10
`define NLS_PWRUP_CYC ((`NLS_PWRUP_US * 1000 + `NLS_CLK_PERIOD_NS - 1) / `NLS_CLK_PERIOD_NS)
`define NLS_LBSY_MIN_MS 1
`define NLS_LBSY_MIN_CYC ((`NLS_LBSY_MIN_MS * 1000000 + `NLS_CLK_PERIOD_NS - 1) / `NLS_CLK_PERIOD_NS)
`define NLS_LBSY_MAX_MS 10
`define NLS_LBSY_MAX_CYC ((`NLS_LBSY_MAX_MS * 1000000) / `NLS_CLK_PERIOD_NS)

// command bytes
`define NLS_CMD_LOCK_STATUS 8'h7A
`define NLS_CMD_STATUS 8'h70
`define NLS_CMD_ERASE_SETUP 8'h60
`define NLS_CMD_ERASE_CONFIRM 8'hD0

// lock status byte layout
`define NLS_LS_TIGHT_BIT 0
`define NLS_LS_LOCKED_BIT 1
`define NLS_LS_UNLOCKED_BIT 2
`define NLS_LS_WP_BIT 7
// ordinary status byte layout
`define NLS_ST_FAIL_BIT 0
`define NLS_ST_READY_BIT 6
`define NLS_ST_WP_BIT 7

`endif

// *** src/nls_pkg.sv ***
package nls_pkg;

   typedef enum logic [1:0] {
      NLS_OP_PROTECT_QUERY = 2'h0,
      NLS_OP_ERASE = 2'h1,
      NLS_OP_SERIAL_READ = 2'h2
   } nls_op_e;

   typedef struct packed {
      nls_op_e op;
      logic [15:0] block;
   } nls_req_s;

   typedef struct packed {
      logic [7:0] data;
      logic via_lock_cmd;
      logic unlocked;
      logic locked;
      logic tight;
      logic not_protected;
      logic long_busy;
      logic timeout;
   } nls_rsp_s;

   typedef struct packed {
      logic cle;
      logic ale;
      logic last;
      logic [7:0] data;
   } nls_cycle_s;

   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic output_strobe_n;
      logic wp_n;
      logic io_oe;
      logic [7:0] io_out;
   } nls_pins_s;

endpackage : nls_pkg

// *** tb/nls_host_checker.sv ***
`timescale 1ns/1ps
// pin-level ordering checks on the host
module nls_host_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire nls_pkg::nls_req_s req,
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire nls_pkg::nls_rsp_s rsp,
   input wire logic lock_feature_enable_pin,
   input wire logic rb_n,
   input wire nls_pkg::nls_pins_s pins
);
   logic [9:0] up_r;
   logic we_q;
   logic setup_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // cycles since reset release, saturating
   always_ff @(posedge ref_clk) begin
      up_r <= rst ? 10'h000 : up_r + {9'h000, up_r != 10'h3FF};
   end
   always_ff @(posedge ref_clk) begin
      we_q <= pins.we_n;
   end
   // erase setup seen; any other command clears it
   always_ff @(posedge ref_clk) begin
      if (rst) setup_r <= 1'b0;
      else if (pins.we_n && !we_q && pins.cle) setup_r <= (pins.io_out == 8'h60);
   end
   property p_rst_quiet;
      disable iff (1'b0) rst |=> !req_ready && !rsp_valid && !pins.wp_n && pins.ce_n;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("host active in reset");
   property p_pwr_wait; req_ready |-> up_r >= 10'h1F3; endproperty
   a_pwr_wait: assert property (p_pwr_wait)
      else $error("ready before power-up wait");
   property p_wp_low; up_r < 10'h1F3 |-> !pins.wp_n; endproperty
   a_wp_low: assert property (p_wp_low)
      else $error("write protect released early");
   property p_busy_refuse;
      (!rb_n) [*3] ##0 (req.op == nls_pkg::NLS_OP_PROTECT_QUERY) |-> !req_ready;
   endproperty
   a_busy_refuse: assert property (p_busy_refuse)
      else $error("query offered while busy");
   property p_confirm; pins.we_n && !we_q && pins.cle && pins.io_out == 8'hD0 |-> setup_r; endproperty
   a_confirm: assert property (p_confirm)
      else $error("confirm without setup");
   property p_strobe_ce; !pins.output_strobe_n |-> !pins.ce_n && !pins.io_oe; endproperty
   a_strobe_ce: assert property (p_strobe_ce)
      else $error("read strobe without select");
   property p_strobe_rd; $fell(pins.output_strobe_n) |-> !pins.cle && !pins.ale; endproperty
   a_strobe_rd: assert property (p_strobe_rd)
      else $error("read strobe in command cycle");
   property p_cmd_pin;
      pins.we_n && !we_q && pins.cle && pins.io_out inside {8'h7A, 8'h70}
         |-> (pins.io_out == 8'h7A) == lock_feature_enable_pin;
   endproperty
   a_cmd_pin: assert property (p_cmd_pin)
      else $error("status command ignores lock pin");
   c_query: cover property (rsp_valid && rsp.via_lock_cmd);
   c_long: cover property (rsp_valid && rsp.long_busy);
   c_refuse: cover property (!rb_n && req_valid && !req_ready);
endmodule : nls_host_checker

bind nls_host nls_host_checker i_nls_host_checker (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
   .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
   .lock_feature_enable_pin(lock_feature_enable_pin), .rb_n(rb_n), .pins(pins));

// *** tb/nls_dev_model.sv ***
`timescale 1ns/1ps
// behavioural flash: lock status, status, first page, busy
module nls_dev_model #(
   parameter int LBSY_CYC = 120,
   parameter int ERS_CYC = 20,
   parameter logic [7:0] PAGE0 = 8'hA5
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic lock_pin,
   input wire nls_pkg::nls_pins_s pins,
   output logic [7:0] dq,
   output logic busy
);
   logic we_q;
   logic lock_r;
   logic sel;
   logic [7:0] cmd_r;
   logic [7:0] page_r;
   logic [7:0] val;
   logic [7:0] last_r = 8'h00;
   logic [1:0] ac_r;
   int cnt_r;
   assign busy = cnt_r != 0;
   assign sel = !pins.ce_n && !pins.output_strobe_n;
   assign val = (cmd_r == 8'h7A && lock_r) ? {pins.wp_n, 7'h02} :
      (cmd_r == 8'h70) ? {pins.wp_n, !busy, 6'h00} : page_r;
   // a released bus must not look like held data
   assign dq = sel ? val : ~last_r;
   always @(posedge ref_clk) begin
      we_q <= pins.we_n;
      last_r <= sel ? val : last_r;
      if (rst) begin
         lock_r <= lock_pin;
         page_r <= lock_pin ? PAGE0 : 8'h00;
         cmd_r <= 8'h00;
         cnt_r <= 0;
         ac_r <= 2'h0;
      end else begin
         if (cnt_r != 0) cnt_r <= cnt_r - 1;
         if (pins.we_n && !we_q && !pins.ce_n && pins.cle) begin
            cmd_r <= pins.io_out;
            ac_r <= 2'h0;
            if (pins.io_out == 8'hD0 && cmd_r == 8'h60 && ac_r == 2'h2) cnt_r <= lock_r ? LBSY_CYC : ERS_CYC;
         end else if (pins.we_n && !we_q && !pins.ce_n && pins.ale) ac_r <= ac_r + 2'h1;
      end
   end
endmodule : nls_dev_model

// *** tb/nls_host_tb.sv ***
`timescale 1ns/1ps
// drives host requests, scores answers against the device model
module nls_host_tb;
   typedef struct packed {
      logic [1:0] op;
      logic [7:0] d;
      logic f;
   } nls_exp_s;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic other_busy = 1'b0;
   logic lock_pin = 1'b1;
   nls_pkg::nls_req_s req = '0;
   logic req_ready;
   logic rsp_valid;
   logic busy;
   nls_pkg::nls_rsp_s rsp;
   nls_pkg::nls_pins_s pins;
   logic [7:0] dq;
   nls_exp_s e;
   logic [7:0] rsp_flags;
   nls_exp_s exp_q[$];
   int err_total = 0;
   int num_checks = 0;
   // pull-up line, any party may pull it low
   wire logic rb_n = !(busy || other_busy);
   wire logic [7:0] io_in = pins.io_oe ? pins.io_out : dq;
   always #10 ref_clk = ~ref_clk;
   nls_host #(.BUSY_TIMEOUT_CYC(20'h000C8), .LONG_BUSY_CYC(20'h00032)) i_nls_host (.ref_clk(ref_clk), .rst(rst),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .lock_feature_enable_pin(lock_pin), .rb_n(rb_n), .io_in(io_in), .pins(pins));
   nls_dev_model #(.LBSY_CYC(120), .ERS_CYC(20)) i_nls_dev_model (.ref_clk(ref_clk), .rst(rst),
      .lock_pin(lock_pin), .pins(pins), .dq(dq), .busy(busy));
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      num_checks++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // offer one request, note its answer, wait until it is scored
   task automatic send(input logic [1:0] op, input logic [7:0] d, input logic f);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req <= '{op: nls_pkg::nls_op_e'(op), block: 16'($urandom)};
      do begin
         @(posedge ref_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 800);
      exp_q.push_back(nls_exp_s'{op, d, f});
      req_valid <= 1'b0;
      while (exp_q.size() != 0 && n < 1600) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 800 && exp_q.size() != 0) begin
         err_total++;
         stop_test();
      end
   endtask : send
   // scoring on the falling edge, where the pulse is settled
   always @(negedge ref_clk) begin
      if (rsp_valid === 1'b1) begin
         // an answer with no request behind it is a fault of its own
         if (exp_q.size() == 0) begin
            chk({7'h00, rsp_valid}, 8'h00);
         end else begin
            e = exp_q.pop_front();
            if (e.op == 2'h1) chk({6'h00, rsp.long_busy, rsp.timeout}, {6'h00, e.f, 1'b0});
            else chk(rsp.data, e.d);
            if (e.op == 2'h0) begin
               chk({7'h00, rsp.via_lock_cmd}, {7'h00, e.f});
               // flags: lock byte bits 2,1,0 only via lock command; bit 7 always
               rsp_flags = {4'h0, rsp.unlocked, rsp.locked, rsp.tight, rsp.not_protected};
               chk(rsp_flags, {4'h0, e.f & e.d[2], e.f & e.d[1], e.f & e.d[0], e.d[7]});
            end
         end
      end
   end
   initial begin
      void'($urandom(32'hBDAC2DB9));
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      send(2'h2, 8'hA5, 1'b0);
      send(2'h0, 8'h82, 1'b1);
      send(2'h2, 8'h82, 1'b0);
      send(2'h1, 8'h00, 1'b1);
      other_busy <= 1'b1;
      repeat (4) @(posedge ref_clk);
      req <= '{op: nls_pkg::NLS_OP_PROTECT_QUERY, block: 16'h0000};
      req_valid <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         chk({7'h00, req_ready}, 8'h00);
      end
      // withdraw the refused offer so the next one is a fresh request
      req_valid <= 1'b0;
      other_busy <= 1'b0;
      @(posedge ref_clk);
      send(2'h0, 8'h82, 1'b1);
      rst <= 1'b1;
      lock_pin <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      send(2'h2, 8'h00, 1'b0);
      send(2'h0, 8'hC0, 1'b0);
      send(2'h1, 8'h00, 1'b0);
      stop_test();
   end
endmodule : nls_host_tb
